// ### bench/sbbd_decoder_bench.sv
// Decoder bench: fetch model, note queue, monitor.
// Assumes package and checker compiled first.
`timescale 1ns/1ps
`default_nettype none

module sbbd_decoder_bench
    import sbbd_pkg::*;
;
    // Expected answer per instruction
    typedef struct packed {
        logic flt;
        sbbd_op_e op;
        sbbd_cost_s cost;
        logic [31:0] n;
        logic [4:0] x;
    } sbbd_note_s;

    logic clock, reset_n, io_permit, addr32;
    wire logic instr_valid;
    wire sbbd_instr_s instr;
    sbbd_mode_e mode;
    logic [1:0] current_privilege, io_privilege_level;
    sbbd_target_e target;
    logic [4:0] param_count, result_params;
    logic [31:0] count_reg, result_elems, seed;
    logic result_valid, fault_valid;
    sbbd_op_e result_op;
    sbbd_cost_s result_cost;
    logic [7:0] fault_vector;
    int mismatches, num_checks;
    sbbd_note_s notes[$];
    sbbd_note_s seen;
    // Protected far bases by target
    logic [15:0] cd[7] = '{16'h22, 16'h34, 16'h56, 16'h5e, 16'h111, 16'h12c, 16'hd9};
    logic [15:0] ci[7] = '{16'h26, 16'h38, 16'h5a, 16'h62, 16'h111, 16'h12c, 16'hd9};
    logic [15:0] jd[7] = '{16'h1b, 16'h2d, 16'h2d, 16'h2d, 16'h112, 16'h12f, 16'hdc};
    logic [15:0] ji[7] = '{16'h1f, 16'h31, 16'h31, 16'h31, 16'h134, 16'h134, 16'h134};

    sbbd_fetch_model i_fetch (.clock(clock), .instr_valid(instr_valid), .instr(instr));
    sbbd_decoder i_dut (.clock(clock), .reset_n(reset_n), .instr_valid(instr_valid),
        .instr(instr), .mode(mode), .current_privilege(current_privilege),
        .io_privilege_level(io_privilege_level), .target(target),
        .param_count(param_count), .io_permit(io_permit), .addr32(addr32),
        .count_reg(count_reg), .result_valid(result_valid), .result_op(result_op),
        .result_cost(result_cost), .result_elems(result_elems),
        .result_params(result_params), .fault_valid(fault_valid),
        .fault_vector(fault_vector));

    ////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, s);
        num_checks++;
        if (e !== s)
        begin
            $display("Error %s expected %h seen %h", nm, e, s);
            mismatches++;
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // One instruction; op NONE with nonzero base is a fault
    task automatic go(input logic [7:0] b0, b1, b2, input sbbd_op_e op,
        input logic [15:0] bs, input logic [3:0] pe, input logic [2:0] pp, input logic am);
        sbbd_note_s nt;
        seed = lfsr(seed);
        count_reg = seed;
        addr32 = seed[31];
        param_count = seed[20:16];
        nt.flt = (op == SBBD_NONE);
        nt.op = op;
        nt.cost = {bs, pe, pp, am};
        nt.n = seed[31] ? seed : {16'h0, seed[15:0]};
        nt.x = seed[20:16];
        // Unknown opcodes leave no note
        if (op != SBBD_NONE || bs != 16'h0000)
            notes.push_back(nt);
        i_fetch.issue(b0, b1, b2);
    endtask

    ////////////////////////////////////////////////////////////
    // Clock at 250 MHz
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Monitor: each answer takes the oldest note
    always @(negedge clock)
    begin
        if (reset_n === 1'b1 && (result_valid === 1'b1 || fault_valid === 1'b1))
        begin
            if (notes.size() == 0)
                chk("spare answer", 64'h0, 64'h1);
            else
            begin
                seen = notes.pop_front();
                chk("valid", !seen.flt, result_valid);
                chk("fault", seen.flt, fault_valid);
                if (seen.flt)
                    chk("vector", 8'h0d, fault_vector);
                else
                begin
                    chk("op", seen.op, result_op);
                    chk("cost", seen.cost, result_cost);
                    chk("elems", seen.n, result_elems);
                    chk("params", seen.x, result_params);
                end
            end
        end
    end

    // Watchdog
    initial
    begin
        repeat (3000) @(posedge clock);
        mismatches++;
        results();
    end

    ////////////////////////////////////////////////////////////
    initial
    begin
        reset_n = 1'b0;
        mode = SBBD_REAL;
        io_permit = 1'b1;
        seed = 32'h3a;
        repeat (8) @(negedge clock);
        reset_n = 1'b1;
        @(negedge clock);
        // Repeated strings in every mode, both widths
        for (int i = 0; i < 3; i++)
        begin
            mode = sbbd_mode_e'(i);
            go(8'hf2, 8'ha6 | i[0], 0, SBBD_SCMP, 5, 9, 0, 0);
            go(8'hf2, 8'hac | i[0], 0, SBBD_SLOD, 5, 6, 0, 0);
            go(8'hf2, 8'ha4 | i[0], 0, SBBD_SMOV, 7, 4, 0, 0);
            go(8'hf3, 8'hae | i[0], 0, SBBD_SCAN_NE, 5, 8, 0, 0);
            go(8'hf2, 8'hae | i[0], 0, SBBD_SCAN_EQ, 5, 8, 0, 0);
            go(8'hf2, 8'haa | i[0], 0, SBBD_SSTO, 5, 5, 0, 0);
        end
        // Port strings by mode and privilege
        mode = SBBD_REAL;
        go(8'hf2, 8'h6c, 0, SBBD_SINS, 13, 6, 0, 0);
        go(8'hf2, 8'h6f, 0, SBBD_SOUT, 12, 5, 0, 0);
        mode = SBBD_PROT;
        current_privilege = 2'h1;
        io_privilege_level = 2'h1;
        go(8'hf2, 8'h6d, 0, SBBD_SINS, 7, 6, 0, 0);
        go(8'hf2, 8'h6e, 0, SBBD_SOUT, 6, 5, 0, 0);
        current_privilege = 2'h2;
        go(8'hf2, 8'h6c, 0, SBBD_SINS, 27, 6, 0, 0);
        go(8'hf2, 8'h6e, 0, SBBD_SOUT, 26, 5, 0, 0);
        mode = SBBD_COMPAT;
        go(8'hf2, 8'h6c, 0, SBBD_SINS, 13, 6, 0, 0);
        io_permit = 1'b0;
        go(8'hf2, 8'h6c, 0, SBBD_NONE, 13, 0, 0, 0);
        go(8'hf2, 8'h6f, 0, SBBD_NONE, 13, 0, 0, 0);
        go(8'hf2, 8'ha6, 0, SBBD_SCMP, 5, 9, 0, 0);
        i_fetch.idle(3);
        // Bit scans in memory form only; bit tests in both operand forms
        mode = SBBD_REAL;
        io_permit = 1'b1;
        go(8'h0f, 8'hbc, 0, SBBD_BSF, 10, 3, 0, 0);
        go(8'h0f, 8'hbd, 0, SBBD_BSR, 10, 3, 0, 0);
        for (int r = 4; r < 8; r++)
            for (int md = 0; md < 2; md++)
                go(8'h0f, 8'hba, {md[0], md[0], r[2:0], 3'h0}, sbbd_op_e'(r == 4 ? 5'h0b
                    : 5'h13 - r[4:0]), r == 4 ? (md ? 3 : 6) : (md ? 6 : 8), 0, 0, 0);
        for (int md = 0; md < 2; md++)
        begin
            go(8'h0f, 8'ha3, {md[0], md[0], 6'h0}, SBBD_BT, md ? 3 : 12, 0, 0, 0);
            go(8'h0f, 8'hab, {md[0], md[0], 6'h0}, SBBD_BTS, md ? 6 : 13, 0, 0, 0);
            go(8'h0f, 8'hbb, {md[0], md[0], 6'h0}, SBBD_BTC, md ? 6 : 13, 0, 0, 0);
        end
        // Transfers in real mode
        go(8'h9a, 0, 0, SBBD_CALLF, 17, 0, 0, 1);
        go(8'hff, 8'h18, 0, SBBD_CALLF_IND, 22, 0, 0, 1);
        go(8'heb, 0, 0, SBBD_JMP, 7, 0, 0, 1);
        go(8'he9, 0, 0, SBBD_JMP, 7, 0, 0, 1);
        go(8'hff, 8'he0, 0, SBBD_JMP_IND, 7, 0, 0, 1);
        go(8'hff, 8'h20, 0, SBBD_JMP_IND, 10, 0, 0, 1);
        go(8'hea, 0, 0, SBBD_JMPF, 12, 0, 0, 1);
        go(8'hff, 8'h28, 0, SBBD_JMPF_IND, 17, 0, 0, 1);
        go(8'h90, 0, 0, SBBD_NONE, 0, 0, 0, 0);
        // Every protected target kind
        mode = SBBD_PROT;
        for (int t = 0; t < 7; t++)
        begin
            target = sbbd_target_e'(t);
            go(8'h9a, 0, 0, SBBD_CALLF, cd[t], 0, t == 3 ? 4 : 0, t < 4);
            go(8'hff, 8'h18, 0, SBBD_CALLF_IND, ci[t], 0, t == 3 ? 4 : 0, t < 4);
            go(8'hea, 0, 0, SBBD_JMPF, jd[t], 0, 0, t < 4);
            go(8'hff, 8'h28, 0, SBBD_JMPF_IND, ji[t], 0, 0, t < 4);
        end
        go(8'heb, 0, 0, SBBD_JMP, 7, 0, 0, 1);
        // Reset in mid-run clears the answer
        i_fetch.idle(2);
        reset_n = 1'b0;
        @(negedge clock);
        chk("reset valid", 1'b0, result_valid);
        chk("reset op", SBBD_NONE, result_op);
        reset_n = 1'b1;
        @(negedge clock);
        go(8'hf2, 8'ha6, 0, SBBD_SCMP, 5, 9, 0, 0);
        i_fetch.idle(3);
        chk("notes left", 0, notes.size());
        results();
    end
endmodule

`default_nettype wire

// ### bench/sbbd_decoder_properties.sv
// Decoder checker, bound to its ports.
// Assumes one clock; answers one cycle after the taking edge.
`timescale 1ns/1ps
`default_nettype none

module sbbd_decoder_properties
    import sbbd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fetch and context
    input wire logic instr_valid,
    input wire sbbd_instr_s instr,
    input wire sbbd_mode_e mode,
    input wire logic [1:0] current_privilege,
    input wire logic [1:0] io_privilege_level,
    input wire sbbd_target_e target,
    input wire logic [4:0] param_count,
    input wire logic io_permit,
    input wire logic addr32,
    input wire logic [31:0] count_reg,
    // Decode result
    input wire logic result_valid,
    input wire sbbd_op_e result_op,
    input wire sbbd_cost_s result_cost,
    input wire logic [31:0] result_elems,
    input wire logic [4:0] result_params,
    input wire logic fault_valid,
    input wire logic [7:0] fault_vector
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    // Prefixed string opcode, width bit ignored
    sequence s_rep(logic [7:0] p, op);
        instr_valid && instr.byte0 == p && {instr.byte1[7:1], 1'b0} == op;
    endsequence
    // Reported op, base and per-element figures
    sequence s_done(sbbd_op_e o, logic [15:0] b, logic [3:0] e);
        result_valid && result_op == o && result_cost.base == b && result_cost.per_elem == e;
    endsequence

    a_cmp_cost : assert property (
        s_rep(8'hf2, 8'ha6) |=> s_done(SBBD_SCMP, 16'h5, 4'h9)) else $error("compare cost");
    a_ins_denied : assert property (
        s_rep(8'hf2, 8'h6c) && mode == SBBD_PROT && current_privilege > io_privilege_level
        |=> s_done(SBBD_SINS, 16'h1b, 4'h6)) else $error("port input cost");
    a_port_string_output_permit : assert property (
        s_rep(8'hf2, 8'h6e) && mode == SBBD_PROT && current_privilege <= io_privilege_level
        |=> s_done(SBBD_SOUT, 16'h6, 4'h5)) else $error("port output cost");
    a_move_cost : assert property (
        s_rep(8'hf2, 8'ha4) |=> s_done(SBBD_SMOV, 16'h7, 4'h4)) else $error("move cost");
    a_scan_ne : assert property (
        s_rep(8'hf3, 8'hae) |=> s_done(SBBD_SCAN_NE, 16'h5, 4'h8)) else $error("scan cost");
    a_bit_rev : assert property (
        instr_valid && instr.byte0 == 8'h0f && instr.byte1 == 8'hbd
        |=> s_done(SBBD_BSR, 16'ha, 4'h3)) else $error("bit scan cost");
    a_port_fault : assert property (
        s_rep(8'hf2, 8'h6c) && mode == SBBD_COMPAT && !io_permit
        |=> fault_valid && fault_vector == 8'h0d && !result_valid) else $error("port fault");
    a_elem_count : assert property (
        instr_valid |=> result_elems == ($past(addr32) ? $past(count_reg)
        : ($past(count_reg) & 32'h0000ffff))) else $error("element count");
    a_gate_params : assert property (
        instr_valid && instr.byte0 == 8'h9a && mode == SBBD_PROT && target == SBBD_T_GATE_PAR
        |=> result_cost.base == 16'h5e && result_cost.per_param == 3'h4 && result_cost.add_m
        && result_params == $past(param_count)) else $error("gate call cost");
    a_no_spurious : assert property (
        !instr_valid |=> !result_valid && !fault_valid) else $error("spare answer");
endmodule

bind sbbd_decoder sbbd_decoder_properties i_props (
    .clock(clock), .reset_n(reset_n), .instr_valid(instr_valid), .instr(instr),
    .mode(mode), .current_privilege(current_privilege),
    .io_privilege_level(io_privilege_level), .target(target), .param_count(param_count),
    .io_permit(io_permit), .addr32(addr32), .count_reg(count_reg),
    .result_valid(result_valid), .result_op(result_op), .result_cost(result_cost),
    .result_elems(result_elems), .result_params(result_params),
    .fault_valid(fault_valid), .fault_vector(fault_vector));

`default_nettype wire

// ### bench/sbbd_fetch_model.sv
// Fetch stream model feeding whole instructions.
// Assumes callers enter its tasks at a falling edge.
`timescale 1ns/1ps
`default_nettype none

module sbbd_fetch_model
    import sbbd_pkg::*;
(
    // Clock
    input wire logic clock,
    // Stream out
    output logic instr_valid,
    output sbbd_instr_s instr
);
    initial instr_valid = 1'b0;

    // One instruction per cycle, valid held between calls
    task automatic issue(input logic [7:0] b0, input logic [7:0] b1, input logic [7:0] b2);
        instr_valid = 1'b1;
        instr = {b0, b1, b2};
        @(negedge clock);
    endtask

    // Gap: bytes toggle so stale values look meaningless
    task automatic idle(input int k);
        repeat (k)
        begin
            instr_valid = 1'b0;
            instr = ~instr;
            @(negedge clock);
        end
    endtask
endmodule

`default_nettype wire

// ### core/sbbd_decoder.sv
// Decoder for repeated string, bit and unconditional transfer instructions.
// Assumes whole instructions with a valid strobe; one decode per cycle.
`timescale 1ns/1ps
`default_nettype none

module sbbd_decoder
    import sbbd_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // Fetched instruction
    input wire logic instr_valid,
    input wire sbbd_instr_s instr,
    // Core context
    input wire sbbd_mode_e mode,
    input wire logic [1:0] current_privilege,
    input wire logic [1:0] io_privilege_level,
    input wire sbbd_target_e target,
    input wire logic [4:0] param_count,
    input wire logic io_permit,
    input wire logic addr32,
    input wire logic [31:0] count_reg,
    // Decode result
    output logic result_valid,
    output sbbd_op_e result_op,
    output sbbd_cost_s result_cost,
    output logic [31:0] result_elems,
    output logic [4:0] result_params,
    output logic fault_valid,
    output logic [7:0] fault_vector
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Pack a cost term
    function automatic sbbd_cost_s mk(input logic [15:0] b, input logic [3:0] e,
                                       input logic [2:0] p, input logic m);
        sbbd_cost_s c;
        c.base = b;
        c.per_elem = e;
        c.per_param = p;
        c.add_m = m;
        return c;
    endfunction

    // Far transfer cost in protected mode by target kind
    function automatic sbbd_cost_s far_cost(input sbbd_target_e t, input logic [15:0] plain,
        input logic [15:0] gs, input logic [15:0] gn, input logic [15:0] gp,
        input logic [15:0] to, input logic [15:0] tn, input logic [15:0] tc);
        sbbd_cost_s c;
        c = mk(plain, 4'h0, 3'h0, 1'b1);
        case (t)
            SBBD_T_GATE_SAME: c = mk(gs, 4'h0, 3'h0, 1'b1);
            SBBD_T_GATE_NOPAR: c = mk(gn, 4'h0, 3'h0, 1'b1);
            SBBD_T_GATE_PAR: c = mk(gp, 4'h0, (gp == gs) ? 3'h0 : 3'h4, 1'b1);
            SBBD_T_TASK_OLD: c = mk(to, 4'h0, 3'h0, 1'b0);
            SBBD_T_TASK_NEW: c = mk(tn, 4'h0, 3'h0, 1'b0);
            SBBD_T_TASK_COMPAT: c = mk(tc, 4'h0, 3'h0, 1'b0);
            default: c = mk(plain, 4'h0, 3'h0, 1'b1);
        endcase
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Combinational decode

    logic [7:0] b0; // First byte
    logic [7:0] b1; // Second byte
    logic [2:0] reg1; // Reg field of byte1
    logic [2:0] reg2; // Reg field of byte2
    logic mod_reg; // Register operand form
    logic prot; // Protected-mode rules only
    logic io_ok; // Privilege allows port access
    logic is_string_io; // String port op
    sbbd_op_e next_op; // Decoded operation
    sbbd_cost_s next_cost; // Decoded cost
    logic next_fault; // Port access denied

    assign b0 = instr.byte0;
    assign b1 = instr.byte1;
    assign reg1 = b1[5:3];
    assign reg2 = instr.byte2[5:3];
    assign mod_reg = (instr.byte2[7:6] == 2'b11);
    assign prot = (mode == SBBD_PROT);
    assign io_ok = (current_privilege <= io_privilege_level);

    // Opcode match and cost selection
    always_comb
    begin
        next_op = SBBD_NONE;
        next_cost = mk(16'h0000, 4'h0, 3'h0, 1'b0);
        if (b0 == `SBBD_PFX_UNEQ)
        begin
            // Width bit ignored for every string form
            case ({b1[7:1], 1'b0})
                `SBBD_OP_CMP:
                begin
                    next_op = SBBD_SCMP;
                    next_cost = mk(`SBBD_C_5, 4'h9, 3'h0, 1'b0);
                end
                `SBBD_OP_INS:
                begin
                    next_op = SBBD_SINS;
                    if (!prot)
                        next_cost = mk(`SBBD_C_13, 4'h6, 3'h0, 1'b0);
                    else
                        next_cost = mk(io_ok ? `SBBD_C_7 : `SBBD_C_27, 4'h6, 3'h0, 1'b0);
                end
                `SBBD_OP_LOD:
                begin
                    next_op = SBBD_SLOD;
                    next_cost = mk(`SBBD_C_5, 4'h6, 3'h0, 1'b0);
                end
                `SBBD_OP_MOV:
                begin
                    next_op = SBBD_SMOV;
                    next_cost = mk(`SBBD_C_7, 4'h4, 3'h0, 1'b0);
                end
                `SBBD_OP_PORT_STRING_OUTPUT:
                begin
                    next_op = SBBD_SOUT;
                    if (!prot)
                        next_cost = mk(`SBBD_C_12, 4'h5, 3'h0, 1'b0);
                    else
                        next_cost = mk(io_ok ? `SBBD_C_6 : `SBBD_C_26, 4'h5, 3'h0, 1'b0);
                end
                `SBBD_OP_SCN:
                begin
                    next_op = SBBD_SCAN_EQ;
                    next_cost = mk(`SBBD_C_5, 4'h8, 3'h0, 1'b0);
                end
                `SBBD_OP_STO:
                begin
                    next_op = SBBD_SSTO;
                    next_cost = mk(`SBBD_C_5, 4'h5, 3'h0, 1'b0);
                end
                default:
                begin
                    next_op = SBBD_NONE;
                end
            endcase
        end
        else if (b0 == `SBBD_PFX_REP && {b1[7:1], 1'b0} == `SBBD_OP_SCN)
        begin
            next_op = SBBD_SCAN_NE;
            next_cost = mk(`SBBD_C_5, 4'h8, 3'h0, 1'b0);
        end
        else if (b0 == `SBBD_ESCAPE)
        begin
            case (b1)
                `SBBD_OP_BSF:
                begin
                    next_op = SBBD_BSF;
                    next_cost = mk(`SBBD_C_10, 4'h3, 3'h0, 1'b0);
                end
                `SBBD_OP_BSR:
                begin
                    next_op = SBBD_BSR;
                    next_cost = mk(`SBBD_C_10, 4'h3, 3'h0, 1'b0);
                end
                `SBBD_OP_BIMM:
                begin
                    // Reg field picks the operation
                    case (reg2)
                        `SBBD_REG_BT:
                        begin
                            next_op = SBBD_BT;
                            next_cost = mk(mod_reg ? `SBBD_C_3 : `SBBD_C_6, 4'h0, 3'h0, 1'b0);
                        end
                        `SBBD_REG_BTC: next_op = SBBD_BTC;
                        `SBBD_REG_BTR: next_op = SBBD_BTR;
                        `SBBD_REG_BTS: next_op = SBBD_BTS;
                        default: next_op = SBBD_NONE;
                    endcase
                    if (next_op != SBBD_BT && next_op != SBBD_NONE)
                        next_cost = mk(mod_reg ? `SBBD_C_6 : `SBBD_C_8, 4'h0, 3'h0, 1'b0);
                end
                `SBBD_OP_BTR:
                begin
                    next_op = SBBD_BT;
                    next_cost = mk(mod_reg ? `SBBD_C_3 : `SBBD_C_12, 4'h0, 3'h0, 1'b0);
                end
                `SBBD_OP_BTSR:
                begin
                    next_op = SBBD_BTS;
                    next_cost = mk(mod_reg ? `SBBD_C_6 : `SBBD_C_13, 4'h0, 3'h0, 1'b0);
                end
                `SBBD_OP_BCR:
                begin
                    // Shared encoding for complement and clear; reported as complement
                    next_op = SBBD_BTC;
                    next_cost = mk(mod_reg ? `SBBD_C_6 : `SBBD_C_13, 4'h0, 3'h0, 1'b0);
                end
                default:
                begin
                    next_op = SBBD_NONE;
                end
            endcase
        end
        else
        begin
            case (b0)
                `SBBD_OP_CALLF:
                begin
                    next_op = SBBD_CALLF;
                    if (!prot)
                        next_cost = mk(`SBBD_C_17, 4'h0, 3'h0, 1'b1);
                    else
                        next_cost = far_cost(target, `SBBD_C_34, `SBBD_C_52, `SBBD_C_86,
                            `SBBD_C_94, `SBBD_C_273, `SBBD_C_300, `SBBD_C_217);
                end
                `SBBD_OP_JSHORT, `SBBD_OP_JNEAR:
                begin
                    next_op = SBBD_JMP;
                    next_cost = mk(`SBBD_C_7, 4'h0, 3'h0, 1'b1);
                end
                `SBBD_OP_JFAR:
                begin
                    next_op = SBBD_JMPF;
                    if (!prot)
                        next_cost = mk(`SBBD_C_12, 4'h0, 3'h0, 1'b1);
                    else
                        next_cost = far_cost(target, `SBBD_C_27, `SBBD_C_45, `SBBD_C_45,
                            `SBBD_C_45, `SBBD_C_274, `SBBD_C_303, `SBBD_C_220);
                end
                `SBBD_OP_GRP:
                begin
                    case (reg1)
                        `SBBD_REG_CALLF:
                        begin
                            next_op = SBBD_CALLF_IND;
                            if (!prot)
                                next_cost = mk(`SBBD_C_22, 4'h0, 3'h0, 1'b1);
                            else
                                next_cost = far_cost(target, `SBBD_C_38, `SBBD_C_56, `SBBD_C_90,
                                    `SBBD_C_98, `SBBD_C_273, `SBBD_C_300, `SBBD_C_217);
                        end
                        `SBBD_REG_JIND:
                        begin
                            next_op = SBBD_JMP_IND;
                            next_cost = mk((b1[7:6] == 2'b11) ? `SBBD_C_7 : `SBBD_C_10,
                                4'h0, 3'h0, 1'b1);
                        end
                        `SBBD_REG_JFAR:
                        begin
                            next_op = SBBD_JMPF_IND;
                            if (!prot)
                                next_cost = mk(`SBBD_C_17, 4'h0, 3'h0, 1'b1);
                            else
                                next_cost = far_cost(target, `SBBD_C_31, `SBBD_C_49, `SBBD_C_49,
                                    `SBBD_C_49, `SBBD_C_308, `SBBD_C_308, `SBBD_C_308);
                        end
                        default:
                        begin
                            next_op = SBBD_NONE;
                        end
                    endcase
                end
                default:
                begin
                    next_op = SBBD_NONE;
                end
            endcase
        end
    end

    // Compat-mode port strings obey the permission map
    assign is_string_io = (next_op == SBBD_SINS) || (next_op == SBBD_SOUT);
    assign next_fault = instr_valid && is_string_io && (mode == SBBD_COMPAT) && !io_permit;

    ////////////////////////////////////////////////////////////////////////////
    // Result registers

    // Decode result, one cycle after the strobe
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result_valid <= 1'b0;
            result_op <= SBBD_NONE;
            result_cost <= '0;
        end
        else
        begin
            // A denied port string is no decode
            result_valid <= instr_valid && (next_op != SBBD_NONE) && !next_fault;
            result_op <= instr_valid ? next_op : SBBD_NONE;
            result_cost <= next_cost;
        end
    end

    // Count terms; width follows address size
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            result_elems <= 32'h00000000;
            result_params <= 5'h00;
        end
        else
        begin
            result_elems <= addr32 ? count_reg : {16'h0000, count_reg[15:0]};
            result_params <= param_count;
        end
    end

    // Fault report pulse
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            fault_valid <= 1'b0;
            fault_vector <= 8'h00;
        end
        else
        begin
            fault_valid <= next_fault;
            fault_vector <= next_fault ? `SBBD_FAULT_GP : 8'h00;
        end
    end

endmodule

`default_nettype wire

// ### core/sbbd_defines.svh
// Constants of the string, bit and branch decode block: opcodes and cycle figures.
// Assumes inclusion by bare name from the package.
`ifndef SBBD_DEFINES_SVH
`define SBBD_DEFINES_SVH

// Prefix and escape bytes
`define SBBD_PFX_UNEQ 8'hf2
`define SBBD_PFX_REP 8'hf3
`define SBBD_ESCAPE 8'h0f
// String opcodes, width bit masked off
`define SBBD_OP_CMP 8'ha6
`define SBBD_OP_INS 8'h6c
`define SBBD_OP_LOD 8'hac
`define SBBD_OP_MOV 8'ha4
`define SBBD_OP_PORT_STRING_OUTPUT 8'h6e
`define SBBD_OP_SCN 8'hae
`define SBBD_OP_STO 8'haa
// Escaped opcodes
`define SBBD_OP_BSF 8'hbc
`define SBBD_OP_BSR 8'hbd
`define SBBD_OP_BIMM 8'hba
`define SBBD_OP_BTR 8'ha3
`define SBBD_OP_BTSR 8'hab
`define SBBD_OP_BCR 8'hbb
// Control opcodes
`define SBBD_OP_CALLF 8'h9a
`define SBBD_OP_GRP 8'hff
`define SBBD_OP_JSHORT 8'heb
`define SBBD_OP_JNEAR 8'he9
`define SBBD_OP_JFAR 8'hea
// Reg field codes
`define SBBD_REG_CALLF 3'h3
`define SBBD_REG_JIND 3'h4
`define SBBD_REG_JFAR 3'h5
`define SBBD_REG_BT 3'h4
`define SBBD_REG_BTS 3'h5
`define SBBD_REG_BTR 3'h6
`define SBBD_REG_BTC 3'h7
// Fault vector
`define SBBD_FAULT_GP 8'h0d
// Cycle figures
`define SBBD_C_5 16'h0005
`define SBBD_C_9 16'h0009
`define SBBD_C_13 16'h000d
`define SBBD_C_7 16'h0007
`define SBBD_C_27 16'h001b
`define SBBD_C_6 16'h0006
`define SBBD_C_4 16'h0004
`define SBBD_C_12 16'h000c
`define SBBD_C_26 16'h001a
`define SBBD_C_8 16'h0008
`define SBBD_C_10 16'h000a
`define SBBD_C_3 16'h0003
`define SBBD_C_17 16'h0011
`define SBBD_C_34 16'h0022
`define SBBD_C_52 16'h0034
`define SBBD_C_86 16'h0056
`define SBBD_C_94 16'h005e
`define SBBD_C_273 16'h0111
`define SBBD_C_300 16'h012c
`define SBBD_C_217 16'h00d9
`define SBBD_C_22 16'h0016
`define SBBD_C_38 16'h0026
`define SBBD_C_56 16'h0038
`define SBBD_C_90 16'h005a
`define SBBD_C_98 16'h0062
`define SBBD_C_31 16'h001f
`define SBBD_C_45 16'h002d
`define SBBD_C_49 16'h0031
`define SBBD_C_274 16'h0112
`define SBBD_C_303 16'h012f
`define SBBD_C_220 16'h00dc
`define SBBD_C_308 16'h0134

`endif

// ### core/sbbd_pkg.sv
// Types shared by the decoder and its bench.
// Assumes the defines header sits beside it.
`include "sbbd_defines.svh"

package sbbd_pkg;

    // Execution mode of the core
    typedef enum logic [1:0] {
        SBBD_REAL = 2'b00,
        SBBD_PROT = 2'b01,
        SBBD_COMPAT = 2'b10
    } sbbd_mode_e;

    // Far transfer target kind in protected mode
    typedef enum logic [2:0] {
        SBBD_T_PLAIN = 3'b000,
        SBBD_T_GATE_SAME = 3'b001,
        SBBD_T_GATE_NOPAR = 3'b010,
        SBBD_T_GATE_PAR = 3'b011,
        SBBD_T_TASK_OLD = 3'b100,
        SBBD_T_TASK_NEW = 3'b101,
        SBBD_T_TASK_COMPAT = 3'b110
    } sbbd_target_e;

    // Decoded operation
    typedef enum logic [4:0] {
        SBBD_NONE = 5'h00, SBBD_SCMP = 5'h01, SBBD_SINS = 5'h02, SBBD_SLOD = 5'h03,
        SBBD_SMOV = 5'h04, SBBD_SOUT = 5'h05, SBBD_SCAN_NE = 5'h06, SBBD_SCAN_EQ = 5'h07,
        SBBD_SSTO = 5'h08, SBBD_BSF = 5'h09, SBBD_BSR = 5'h0a, SBBD_BT = 5'h0b,
        SBBD_BTC = 5'h0c, SBBD_BTR = 5'h0d, SBBD_BTS = 5'h0e, SBBD_CALLF = 5'h0f,
        SBBD_CALLF_IND = 5'h10, SBBD_JMP = 5'h11, SBBD_JMP_IND = 5'h12,
        SBBD_JMPF = 5'h13, SBBD_JMPF_IND = 5'h14
    } sbbd_op_e;

    // Three instruction bytes
    typedef struct packed {
        logic [7:0] byte0;
        logic [7:0] byte1;
        logic [7:0] byte2;
    } sbbd_instr_s;

    // Cycle report: base plus unit times count terms
    typedef struct packed {
        logic [15:0] base;
        logic [3:0] per_elem;
        logic [2:0] per_param;
        logic add_m;
    } sbbd_cost_s;

endpackage
